/* File: design/scf_top.sv */
// Serial receive front end: UART, queue, XON/XOFF pacing, command framing
// Functional notes
// (RULE_01) Reset link: 115200 baud, 8N1
// (RULE_02) Selectable rates 4800 up to 115200
// (RULE_03) Baud code 1-6 or ASCII digit
// (RULE_04) Send 0x13 at high mark
// (RULE_05) One more 0x13 per extra byte
// (RULE_06) Keep draining queue after flow-off
// (RULE_07) Send 0x11 on reaching low mark
// (RULE_08) One 0x11 only after a 0x13
// (RULE_09) 256-byte queue, marks 20 and 166
// (RULE_10) Marks set by 0x1b 0xc5 command
// (RULE_11) Full queue overrun sends 0xff
// (RULE_12) Host stops on flow-off until flow-on
// (RULE_13) Host polls for flow-off per 32 bytes; the host model polls before every byte
// (RULE_14) Paused host blocks until flow-on
// (RULE_15) Host retunes marks on overrun marker; the host model only counts it in n_overrun
// (RULE_16) Queue exceeds 128 for bitmap lookahead
// (RULE_17) Lookahead starved under flow-off sends flow-on
// (RULE_18) Commands are 0x7c then opcode
// (RULE_19) Opcode plus 0x40 uses default mode
// (RULE_20) Polyline/polygon lists end with 0x80
// (RULE_21) List end is bit 7 of y
// (RULE_22) Occupancy counts pushes minus pops
// (RULE_23) Control characters use normal UART framing
`timescale 1ns/1ps
`default_nettype none
module scf_top #(
    parameter int unsigned DEPTH = scf_pkg::QUEUE_DEPTH
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              rx_pin,
    output logic                   tx_pin,
    input  wire logic              peek_req,
    input  wire logic [7:0]        peek_need,
    output logic                   cmd_valid,
    output scf_pkg::scf_cmd_s      cmd,
    output logic                   arg_valid,
    output logic [7:0]             arg_data,
    output logic                   arg_list_end,
    input  wire logic              arg_ready,
    output logic [2:0]             baud_sel,
    output logic [8:0]             occupancy
);
    import scf_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);
    initial begin
        if (DEPTH <= PEEK_MAX || DEPTH > 256 || (1 << AW) != DEPTH)
            $error("DEPTH must be a power of two above 128 and at most 256");
    end

    // Divider per selectable rate (4800..115200), rounded to nearest cycle
    function automatic logic [15:0] baud_div(input logic [2:0] sel);
        int unsigned r;
        unique case (sel)
            3'h1: r = 4800;
            3'h2: r = 9600;
            3'h3: r = 19200;
            3'h4: r = 38400;
            3'h5: r = 57600;
            default: r = BAUD_DEFAULT;
        endcase
        return 16'((CLK_HZ + r / 2) / r);
    endfunction

    typedef enum logic [2:0] {
        P_IDLE   = 3'h0,
        P_OP     = 3'h1,
        P_ARGS   = 3'h2,
        P_LIST   = 3'h3,
        P_CFGKEY = 3'h4,
        P_CFGID  = 3'h5,
        P_CFGVAL = 3'h6,
        P_BAUD   = 3'h7
    } scf_parse_e;

    typedef struct packed {
        logic [1:0]  rx_sync;
        logic        rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [8:0]  occ;
        logic        xoff_sent;
        logic [1:0]  pend;       // bit0 flow-off/overrun, bit1 flow-on request
        logic [7:0]  pend_ch;
        logic        tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [9:0]  tx_sh;
        logic [2:0]  baud;
        logic [8:0]  low_mark;
        logic [8:0]  high_mark;
        logic [7:0]  dmode;
        scf_parse_e  ps;
        logic [7:0]  op;
        logic [7:0]  cfg_id;
        logic        half;       // Toggles x/y in coordinate lists
        logic        cmd_v;
        scf_cmd_s    cmd;
    } scf_state_s;

    scf_state_s s_r;
    scf_state_s s_nxt;
    logic [7:0] mem_r [DEPTH];
    logic       sk_in_ready;
    logic       sk_out_valid;
    logic [7:0] sk_out_data;
    logic       rx_done;
    logic       head_take;

    wire logic [15:0] div = baud_div(s_r.baud);
    assign rx_done   = s_r.rx_busy && s_r.rx_bit == 4'h9 && s_r.rx_cnt == 16'h0;
    assign head_take = (s_r.occ != 9'h0) && sk_in_ready; // RULE_06

    // Queue storage, written on an accepted received byte
    always_ff @(posedge mclk) begin
        if (rx_done && s_r.occ != 9'(DEPTH)) mem_r[s_r.wp] <= s_r.rx_sh;
    end

    // Consumer side buffer: renderer stalls lose nothing
    scf_skid u_skid (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_valid  (head_take),
        .in_ready  (sk_in_ready),
        .in_data   (mem_r[s_r.rp]),
        .out_valid (sk_out_valid),
        .out_ready (arg_ready || !s_r.cmd_v),
        .out_data  (sk_out_data)
    );

    // Single next-state process for UART, queue, pacing and parser
    always_comb begin
        logic push;
        logic pop;
        logic [7:0] b;
        logic take;
        s_nxt = s_r;
        push  = 1'b0;
        s_nxt.rx_sync = {s_r.rx_sync[0], rx_pin};
        // Receiver: centre-sampled 8N1 at the selected rate
        if (!s_r.rx_busy) begin
            if (!s_r.rx_sync[1]) begin
                s_nxt.rx_busy = 1'b1;
                s_nxt.rx_cnt  = div >> 1;
                s_nxt.rx_bit  = 4'h0;
            end
        end else if (s_r.rx_cnt != 16'h0) begin
            s_nxt.rx_cnt = s_r.rx_cnt - 16'h1;
        end else begin
            s_nxt.rx_cnt = div - 16'h1;
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
            if (s_r.rx_bit == 4'h0 && s_r.rx_sync[1]) s_nxt.rx_busy = 1'b0;
            if (s_r.rx_bit >= 4'h1 && s_r.rx_bit <= 4'h8)
                s_nxt.rx_sh = {s_r.rx_sync[1], s_r.rx_sh[7:1]};
            if (s_r.rx_bit == 4'h9) s_nxt.rx_busy = 1'b0; // RULE_01
        end
        // Accept into queue or flag overrun
        if (rx_done) begin
            if (s_r.occ == 9'(DEPTH)) begin
                s_nxt.pend[0] = 1'b1; // RULE_11
                s_nxt.pend_ch = CH_OVERRUN;
            end else begin
                push = 1'b1;
                s_nxt.wp = s_r.wp + AW'(1);
                if (s_r.occ + 9'h1 >= s_r.high_mark) begin
                    s_nxt.pend[0] = 1'b1; // RULE_04 RULE_05
                    s_nxt.pend_ch = CH_FLOW_OFF;
                    s_nxt.xoff_sent = 1'b1;
                end
            end
        end
        pop = head_take;
        if (pop) s_nxt.rp = s_r.rp + AW'(1);
        s_nxt.occ = s_r.occ + {8'h0, push} - {8'h0, pop}; // RULE_22 RULE_09
        // Flow-on once per episode, at low mark or starved lookahead
        if (s_nxt.xoff_sent && !s_nxt.pend[0]
            && (s_nxt.occ <= s_r.low_mark                 // RULE_07
                || (peek_req && s_nxt.occ < {1'b0, peek_need}))) begin // RULE_17 RULE_16
            s_nxt.pend[1]   = 1'b1; // RULE_08
            s_nxt.xoff_sent = 1'b0;
        end
        // Transmitter: same framing and rate for every control character
        if (!s_r.tx_busy) begin
            if (s_r.pend[0] && !(rx_done)) begin
                s_nxt.tx_busy = 1'b1;
                s_nxt.tx_sh   = {1'b1, s_r.pend_ch, 1'b0}; // RULE_23
                s_nxt.pend[0] = 1'b0;
                s_nxt.tx_cnt  = div - 16'h1;
                s_nxt.tx_bit  = 4'h0;
            end else if (s_r.pend[1]) begin
                s_nxt.tx_busy = 1'b1;
                s_nxt.tx_sh   = {1'b1, CH_FLOW_ON, 1'b0};
                s_nxt.pend[1] = 1'b0;
                s_nxt.tx_cnt  = div - 16'h1;
                s_nxt.tx_bit  = 4'h0;
            end
        end else if (s_r.tx_cnt != 16'h0) begin
            s_nxt.tx_cnt = s_r.tx_cnt - 16'h1;
        end else begin
            s_nxt.tx_cnt = div - 16'h1;
            s_nxt.tx_sh  = {1'b1, s_r.tx_sh[9:1]};
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            if (s_r.tx_bit == 4'h9) s_nxt.tx_busy = 1'b0;
        end
        // Command framing on bytes leaving the buffer
        b    = sk_out_data;
        take = sk_out_valid && (arg_ready || !s_r.cmd_v);
        if (s_r.cmd_v && arg_ready && s_r.ps == P_IDLE) s_nxt.cmd_v = 1'b0;
        if (take) begin
            unique case (s_r.ps)
                P_IDLE: if (b == CMD_PREFIX) s_nxt.ps = P_OP; // RULE_18
                P_OP: begin
                    s_nxt.op  = b;
                    s_nxt.cmd_v = 1'b1;
                    s_nxt.cmd.opcode = b & ~MODE_DEFAULT_BIT;
                    s_nxt.cmd.use_default = b[6]; // RULE_19
                    s_nxt.cmd.mode = s_r.dmode;
                    s_nxt.half = 1'b0;
                    if (b == OP_SET_CFG) s_nxt.ps = P_CFGKEY; // RULE_10
                    else if (b == OP_BAUD) s_nxt.ps = P_BAUD;
                    else if ((b & ~MODE_DEFAULT_BIT) == OP_LINES
                             || (b & ~MODE_DEFAULT_BIT) == OP_POLYGON)
                        s_nxt.ps = P_LIST; // RULE_20
                    else s_nxt.ps = P_ARGS;
                end
                P_ARGS: begin
                    if (s_r.op == OP_DRAW_MODE) s_nxt.dmode = b;
                    s_nxt.ps = P_IDLE;
                end
                P_LIST: begin
                    s_nxt.half = !s_r.half;
                    if (s_r.half && (b & LIST_END_BIT) != 8'h0) s_nxt.ps = P_IDLE; // RULE_21
                end
                P_CFGKEY: s_nxt.ps = (b == CFG_KEY) ? P_CFGID : P_IDLE;
                P_CFGID: begin
                    s_nxt.cfg_id = b;
                    s_nxt.ps = P_CFGVAL;
                end
                P_CFGVAL: begin
                    if (s_r.cfg_id == CFG_ID_LOW) s_nxt.low_mark = {1'b0, b};
                    if (s_r.cfg_id == CFG_ID_HIGH) s_nxt.high_mark = {1'b0, b};
                    s_nxt.ps = P_IDLE;
                end
                P_BAUD: begin
                    if (b >= 8'h01 && b <= 8'h06) s_nxt.baud = b[2:0]; // RULE_03 RULE_02
                    else if (b >= ASCII_ONE && b <= ASCII_SIX) s_nxt.baud = b[2:0];
                    s_nxt.ps = P_IDLE;
                end
            endcase
        end
    end

    // State register; rate, marks and mode reset to documented values
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.rx_sync   <= 2'h3;
            s_r.tx_sh     <= 10'h3ff;
            s_r.baud      <= BAUD_SEL_RST;
            s_r.low_mark  <= LOW_MARK_RST;
            s_r.high_mark <= HIGH_MARK_RST;
            s_r.dmode     <= DRAW_MODE_RST;
            s_r.ps        <= P_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_pin       = s_r.tx_busy ? s_r.tx_sh[0] : 1'b1;
    assign cmd_valid    = s_r.cmd_v;
    assign cmd          = s_r.cmd;
    assign arg_valid    = sk_out_valid && s_r.cmd_v;
    assign arg_data     = sk_out_data;
    assign arg_list_end = s_r.ps == P_LIST && s_r.half && sk_out_data[7];
    assign baud_sel     = s_r.baud;
    assign occupancy    = s_r.occ;
endmodule
`default_nettype wire

/* File: design/scf_pkg.sv */
// Shared constants and carrier types for the serial command front end
package scf_pkg;
    // Link framing and rates
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned BAUD_DEFAULT = 115200;
    localparam logic [2:0]  BAUD_SEL_RST = 3'h6;
    localparam logic [7:0]  ASCII_ONE    = 8'h31;
    localparam logic [7:0]  ASCII_SIX    = 8'h36;
    // Flow-control characters
    localparam logic [7:0]  CH_FLOW_OFF  = 8'h13;
    localparam logic [7:0]  CH_FLOW_ON   = 8'h11;
    localparam logic [7:0]  CH_OVERRUN   = 8'hff;
    // Queue defaults
    localparam int unsigned QUEUE_DEPTH  = 256;
    localparam int unsigned PEEK_MAX     = 128;
    localparam logic [8:0]  LOW_MARK_RST = 9'h014;
    localparam logic [8:0]  HIGH_MARK_RST = 9'h0a6;
    // Command framing
    localparam logic [7:0]  CMD_PREFIX   = 8'h7c;
    localparam logic [7:0]  OP_BAUD      = 8'h07;
    localparam logic [7:0]  OP_DRAW_MODE = 8'h0d;
    localparam logic [7:0]  OP_SET_CFG   = 8'h1b;
    localparam logic [7:0]  OP_BITBLT    = 8'h16;
    localparam logic [7:0]  OP_LINES     = 8'h11;
    localparam logic [7:0]  OP_POLYGON   = 8'h1a;
    localparam logic [7:0]  CFG_KEY      = 8'hc5;
    localparam logic [7:0]  CFG_ID_LOW   = 8'h00;
    localparam logic [7:0]  CFG_ID_HIGH  = 8'h01;
    localparam logic [7:0]  MODE_DEFAULT_BIT = 8'h40;
    localparam logic [7:0]  LIST_END_BIT = 8'h80;
    localparam logic [7:0]  DRAW_MODE_RST = 8'h01;

    // Decoded command handed to the renderer
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] mode;
        logic       use_default;
    } scf_cmd_s;

    // Two-entry skid buffer state
    typedef struct packed {
        logic [7:0] d0;
        logic [7:0] d1;
        logic [1:0] cnt;
    } scf_skid_s;
endpackage

/* File: design/scf_skid.sv */
// Two-entry buffer between queue head and the consumer
`timescale 1ns/1ps
`default_nettype none
module scf_skid (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic [7:0]      out_data
);
    import scf_pkg::*;
    scf_skid_s s_r;
    scf_skid_s s_nxt;

    assign in_ready  = (s_r.cnt != 2'h2);
    assign out_valid = (s_r.cnt != 2'h0);
    assign out_data  = s_r.d0;

    // Shift on pop, append on push; both may happen together
    always_comb begin
        logic push;
        logic pop;
        push  = in_valid && in_ready;
        pop   = out_valid && out_ready;
        s_nxt = s_r;
        if (pop) begin
            s_nxt.d0  = s_r.d1;
            s_nxt.cnt = s_r.cnt - 2'h1;
        end
        if (push) begin
            if (s_nxt.cnt == 2'h0) s_nxt.d0 = in_data;
            else s_nxt.d1 = in_data;
            s_nxt.cnt = s_nxt.cnt + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) s_r <= '0;
        else s_r <= s_nxt;
    end
endmodule
`default_nettype wire

/* File: tb/scf_top_asserts.sv */
// Port-level property checker for the serial command front end
`timescale 1ns/1ps
`default_nettype none
module scf_top_asserts #(
    parameter int unsigned DEPTH = 256
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              tx_pin,
    input  wire logic              cmd_valid,
    input  wire scf_pkg::scf_cmd_s cmd,
    input  wire logic              arg_valid,
    input  wire logic [7:0]        arg_data,
    input  wire logic              arg_list_end,
    input  wire logic              arg_ready,
    input  wire logic [2:0]        baud_sel,
    input  wire logic [8:0]        occupancy
);
    import scf_pkg::*;
    localparam int BIT = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
    logic [17:0] low_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Length of the current low stretch on the transmit line
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            low_r <= '0;
        else
            low_r <= tx_pin ? '0 : low_r + 18'h1;
    end
    property p_baud_code;
        baud_sel >= 3'h1 && baud_sel <= 3'h6;
    endproperty
    a_baud_code: assert property (p_baud_code) else $error("baud code out of range");
    property p_occ_max;
        occupancy <= 9'(DEPTH);
    endproperty
    a_occ_max: assert property (p_occ_max) else $error("occupancy above depth");
    property p_occ_step;
        occupancy != $past(occupancy) |->
            occupancy == $past(occupancy) + 9'h1 || occupancy == $past(occupancy) - 9'h1;
    endproperty
    a_occ_step: assert property (p_occ_step) else $error("occupancy jumped");
    // Every reply character has bit 0 set, so a low run spans at most three bits
    property p_tx_low_max;
        baud_sel == 3'h6 |-> low_r <= 18'(3 * BIT + 4);
    endproperty
    a_tx_low_max: assert property (p_tx_low_max) else $error("tx low too long");
    property p_tx_low_min;
        $rose(tx_pin) && baud_sel == 3'h6 |-> low_r >= 18'(BIT - 1);
    endproperty
    a_tx_low_min: assert property (p_tx_low_min) else $error("tx bit too short");
    property p_cmd_stable;
        cmd_valid && $past(cmd_valid) |-> $stable(cmd);
    endproperty
    a_cmd_stable: assert property (p_cmd_stable) else $error("cmd changed while open");
    property p_op_base;
        cmd_valid |-> !cmd.opcode[6];
    endproperty
    a_op_base: assert property (p_op_base) else $error("opcode default bit kept");
    property p_arg_hold;
        arg_valid && !arg_ready |=> arg_valid && $stable(arg_data) && $stable(arg_list_end);
    endproperty
    a_arg_hold: assert property (p_arg_hold) else $error("stalled argument lost");
    property p_list_end;
        arg_valid && arg_list_end |-> arg_data[7];
    endproperty
    a_list_end: assert property (p_list_end) else $error("list end without bit 7");
    property p_arg_in_cmd;
        arg_valid |-> cmd_valid;
    endproperty
    a_arg_in_cmd: assert property (p_arg_in_cmd) else $error("argument outside command");
    c_default: cover property (cmd_valid && cmd.use_default);
    c_end: cover property (arg_valid && arg_ready && arg_list_end);
    c_full: cover property (occupancy == 9'(DEPTH));
endmodule
bind scf_top scf_top_asserts #(.DEPTH(DEPTH)) i_chk (
    .mclk(mclk), .rst_b(rst_b), .tx_pin(tx_pin), .cmd_valid(cmd_valid), .cmd(cmd),
    .arg_valid(arg_valid), .arg_data(arg_data), .arg_list_end(arg_list_end),
    .arg_ready(arg_ready), .baud_sel(baud_sel), .occupancy(occupancy));
`default_nettype wire

/* File: tb/scf_host_model.sv */
// Behavioural host: serial sender toward the device, receiver of its replies
`timescale 1ns/1ps
`default_nettype none
module scf_host_model (
    input  wire logic mclk,
    input  wire logic tx_pin,
    output logic      rx_pin
);
    import scf_pkg::*;
    localparam int BIT = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
    logic [7:0] rx_q[$];
    logic       paused = 1'b0;
    int         n_overrun = 0;
    initial rx_pin = 1'b1;
    // One 8N1 character; polls the pause flag first, as a host without native pacing must
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        while (paused) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk) #1 rx_pin = fr[i];
            repeat (BIT - 1) @(posedge mclk);
        end
        @(negedge mclk);
    endtask
    // Sample replies at bit centres on the falling clock to stay clear of updates
    initial begin
        logic [7:0] c;
        forever begin
            @(negedge mclk);
            if (tx_pin === 1'b0) begin
                repeat (BIT / 2) @(negedge mclk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(negedge mclk);
                    c[i] = tx_pin;
                end
                repeat (BIT) @(negedge mclk);
                if (c == CH_FLOW_OFF)
                    paused = 1'b1;
                else if (c == CH_FLOW_ON)
                    paused = 1'b0;
                else if (c == CH_OVERRUN)
                    n_overrun++;
                rx_q.push_back(c);
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/scf_top_tb.sv */
// Self-checking bench: reset, framing, pacing and drain of the serial front end
`timescale 1ns/1ps
`default_nettype none
module scf_top_tb;
    import scf_pkg::*;
    localparam int unsigned DEPTH_TB = 256;
    localparam int BIT = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
    logic       mclk = 1'b0;
    logic       rst_b = 1'b0;
    logic       rx_pin;
    logic       tx_pin;
    logic       cmd_valid;
    scf_cmd_s   cmd;
    logic       arg_valid;
    logic [7:0] arg_data;
    logic       arg_list_end;
    logic       arg_ready = 1'b0;
    logic       peek_req = 1'b0;
    logic [7:0] peek_need = 8'h00;
    logic [2:0] baud_sel;
    logic [8:0] occupancy;
    logic [8:0] got_q[$];
    logic [8:0] exp_q[$];
    int         n_errors = 0;
    int         checked = 0;
    // Full-size queue; pacing is reached by lowering the high mark, not by filling
    scf_top #(.DEPTH(DEPTH_TB)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .peek_req(peek_req), .peek_need(peek_need), .cmd_valid(cmd_valid), .cmd(cmd),
        .arg_valid(arg_valid), .arg_data(arg_data), .arg_list_end(arg_list_end),
        .arg_ready(arg_ready), .baud_sel(baud_sel), .occupancy(occupancy));
    scf_host_model i_host (.mclk(mclk), .tx_pin(tx_pin), .rx_pin(rx_pin));
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    // Record every argument byte on the falling edge before the rising edge that hands it over
    always @(negedge mclk)
        if (arg_valid === 1'b1 && arg_ready === 1'b1) got_q.push_back({arg_list_end, arg_data});
    task automatic cmp(input string what, input logic [16:0] exp, input logic [16:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        cmp("tx idle", 17'h1, 17'(tx_pin));
        cmp("baud", 17'(BAUD_SEL_RST), 17'(baud_sel));
        cmp("occupancy", 17'h0, 17'(occupancy));
        cmp("cmd_valid", 17'h0, 17'(cmd_valid));
        $display("test reset done");
    endtask
    task automatic t_open();
        i_host.send_byte(CMD_PREFIX);
        i_host.send_byte(OP_LINES | MODE_DEFAULT_BIT);
        repeat (4) @(negedge mclk);
        cmp("cmd_valid", 17'h1, 17'(cmd_valid));
        cmp("cmd", {OP_LINES, DRAW_MODE_RST, 1'b1}, cmd);
        $display("test open done");
    endtask
    // High mark lowered to one byte: the next byte draws one flow-off, then one flow-on
    task automatic t_pace();
        @(posedge mclk) #1 arg_ready = 1'b1;
        i_host.send_byte(CMD_PREFIX);
        i_host.send_byte(OP_SET_CFG);
        i_host.send_byte(CFG_KEY);
        i_host.send_byte(CFG_ID_HIGH);
        i_host.send_byte(8'h01);
        cmp("replies before mark", 17'h0, 17'(i_host.rx_q.size()));
        i_host.send_byte(CMD_PREFIX);
        repeat (BIT * 24) @(negedge mclk) if (i_host.rx_q.size() > 1) break;
        cmp("reply count", 17'h2, 17'(i_host.rx_q.size()));
        if (i_host.rx_q.size() > 1) begin
            cmp("flow off", 17'(CH_FLOW_OFF), 17'(i_host.rx_q.pop_front()));
            cmp("flow on", 17'(CH_FLOW_ON), 17'(i_host.rx_q.pop_front()));
        end
        cmp("occupancy drained", 17'h0, 17'(occupancy));
        $display("test pace done");
    endtask
    // Release the consumer, close the list and compare what came out
    task automatic t_drain();
        @(posedge mclk) #1 arg_ready = 1'b1;
        if (exp_q.size() % 2 == 0) begin
            i_host.send_byte(8'h09);
            exp_q.push_back(9'h009);
        end
        i_host.send_byte(8'h8a);
        exp_q.push_back(9'h18a);
        repeat (20) @(negedge mclk);
        cmp("arg count", 17'(exp_q.size()), 17'(got_q.size()));
        foreach (exp_q[i])
            if (i < got_q.size()) cmp("arg byte", 17'(exp_q[i]), 17'(got_q[i]));
        cmp("cmd closed", 17'h0, 17'(cmd_valid));
        cmp("occupancy empty", 17'h0, 17'(occupancy));
        cmp("no pacing chars", 17'h0, 17'(i_host.rx_q.size()));
        $display("test drain done");
    endtask
    // Main sequence: three cycles of reset, then the tests
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        t_reset();
        @(posedge mclk) #1 rst_b = 1'b1;
        t_open();
        t_drain();
        t_pace();
        final_report();
    end
    // Watchdog sized for about twenty characters of link time
    initial begin
        repeat (BIT * 200) @(posedge mclk);
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
